// ---- design/scan_video_mux_framer.sv ----
// How it works
// - Every channel sampled once per 10 us.
// - Image sampling only during forward sweep.
// - Scan-start pulse starts each line's sampling.
// - Idle line alternates two 6-bit preamble words, repeating every 12 bits.
// - Word after scan pulse is inverted preamble.
// - Sync code follows marker, then commutator resets.
// - First sample after reset is band 1 A.
// - First cycle carries time code, not image.
// - Mode picks linear or compressed encoding path.
// - Band 4 channels always linear.
// - 15 Mbps serial data sent with clock.
`timescale 1ns/1ps
`default_nettype none
module scan_video_mux_framer
  import scan_mux_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         scanPulse,     // Mirror angle monitor pulse
  input  wire logic         compressMode,  // High selects the compression path
  input  wire logic [143:0] videoIn,       // 24 channels x 6 bits, channel 0 in low bits
  input  wire logic [143:0] timeCode,      // 24 spacecraft time words
  output logic              serData,       // Serial stream, MSB first
  output logic              serClk,        // Bit clock, rises mid-bit
  output logic              sweepActive    // High while time-code and image cycles run
);

  framer_state_t state;           // Framer state
  logic [15:0]   rateAcc;         // Fractional bit-rate accumulator
  logic          bitEn;           // One bit period elapsed
  logic          bitEnDly;        // Bit enable one clock later, for the bit clock
  logic          compressMeta;    // First synchroniser stage of the mode pin
  logic          compressSync;    // Mode pin, safe to read in core_clk
  logic [2:0]    bitCnt;          // Bit within word
  logic          wordEnd;         // Last bit of a word ends now
  logic [5:0]    shiftReg;        // Word on the line
  logic          prePhase;        // Which preamble word is due
  logic [4:0]    chan;            // Next commutator slot
  logic          firstCycle;      // Time-code cycle flag
  logic [1:0]    pulseCnt;        // Crossings seen this sweep
  logic          markPending;     // Scan start awaiting a word edge
  logic          sweepDone;       // East edge reached
  logic [2:0]    pulseSync;       // Two-flop synchroniser plus edge history
  logic          pulseRise;       // Clean rising edge of the monitor pulse
  logic [143:0]  videoMeta;       // First synchroniser stage
  logic [143:0]  videoSync;       // Second synchroniser stage
  logic [143:0]  timeMeta;
  logic [143:0]  timeSync;
  logic [5:0]    preWord;         // Preamble word that is due
  logic [5:0]    linSample;       // Selected raw channel value
  logic [5:0]    encSample;       // Output of the encoder
  logic [5:0]    timeWord;        // Selected time word
  logic          useCompress;     // Compression applied to this slot
  logic          sampleLoad;      // An image or time slot loads now
  logic [5:0]    next_word;       // Word loaded at the coming boundary

  // Bit-rate enable: 15 of every 40 core clocks carry a bit edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rateAcc <= 16'h0000;
      bitEn   <= 1'b0;
    end else if (rateAcc + 16'(BIT_RATE_KHZ) >= 16'(CORE_CLK_KHZ)) begin
      rateAcc <= rateAcc + 16'(BIT_RATE_KHZ) - 16'(CORE_CLK_KHZ);
      bitEn   <= 1'b1;
    end else begin
      rateAcc <= rateAcc + 16'(BIT_RATE_KHZ);
      bitEn   <= 1'b0;
    end
  end

  // Clock out rises one clock after data changes, so the receiver samples settled data;
  // bit edges are at least two clocks apart, so the pulse ends no later than the next change
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bitEnDly <= 1'b0;
      serClk   <= 1'b0;
    end else begin
      bitEnDly <= bitEn;     // High in the clock where the new bit appears
      serClk   <= bitEnDly;
    end
  end

  // Pin inputs cross into core_clk through two flops before any use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulseSync    <= 3'h0;
      compressMeta <= 1'b0;
      compressSync <= 1'b0;
      videoMeta <= '0;
      videoSync <= '0;
      timeMeta  <= '0;
      timeSync  <= '0;
    end else begin
      pulseSync    <= {pulseSync[1:0], scanPulse};
      compressMeta <= compressMode;  // Mode is a command level from outside this clock
      compressSync <= compressMeta;
      videoMeta <= videoIn;
      videoSync <= videoMeta;
      timeMeta  <= timeCode;
      timeSync  <= timeMeta;
    end
  end

  // Edge taken only from the second and third stages
  assign pulseRise = pulseSync[1] & ~pulseSync[2];
  assign wordEnd   = bitEn && (bitCnt == 3'(WORD_BITS - 1));

  // Bit position within the current word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bitCnt <= 3'h0;
    end else if (bitEn) begin
      bitCnt <= wordEnd ? 3'h0 : bitCnt + 3'h1;
    end
  end

  // Slot selection; channel index runs band by band, A to F inside each
  always_comb begin
    linSample   = videoSync[chan * WORD_BITS +: WORD_BITS];
    timeWord    = timeSync[chan * WORD_BITS +: WORD_BITS];
    preWord     = prePhase ? PREAMBLE_B : PREAMBLE_A;
    useCompress = compressSync && (chan < 5'(BAND4_FIRST));
  end

  // Encoder sits between commutator and line
  sample_encoder u_encoder (
    .linSample (linSample),
    .compress  (useCompress),
    .code      (encSample)
  );

  assign sampleLoad = wordEnd && (state == ST_SAMPLE) && (chan < 5'(NUM_CHAN));

  // Word chosen for the next boundary
  always_comb begin
    next_word = FILL_WORD;
    case (state)
      ST_PREAMBLE: begin
        next_word = markPending ? ~preWord : preWord;
      end
      ST_SYNC: begin
        next_word = SYNC_CODE;
      end
      ST_SAMPLE: begin
        if (chan < 5'(NUM_CHAN)) begin
          next_word = firstCycle ? timeWord : encSample;
        end else begin
          next_word = FILL_WORD;  // Spare slot rounds the cycle to 10 us
        end
      end
      default: begin
        next_word = FILL_WORD;
      end
    endcase
  end

  // Shift register: load at word boundaries, shift on other bit edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shiftReg <= PREAMBLE_A;
    end else if (wordEnd) begin
      shiftReg <= next_word;
    end else if (bitEn) begin
      shiftReg <= {shiftReg[4:0], 1'b0};
    end
  end

  assign serData = shiftReg[5];

  // Preamble alternates; the marked word still advances the pattern
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prePhase <= 1'b0;
    end else if (wordEnd && state == ST_PREAMBLE) begin
      prePhase <= ~prePhase;
    end
  end

  // Scan pulses: first one arms a line, the third marks the east edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pulseCnt    <= 2'h0;
      markPending <= 1'b0;
      sweepDone   <= 1'b0;
    end else begin
      if (state == ST_PREAMBLE && wordEnd) begin
        markPending <= pulseRise;  // Consumed by the marker word
      end else if (pulseRise && state == ST_PREAMBLE) begin
        markPending <= 1'b1;
      end
      if (state == ST_PREAMBLE && wordEnd && markPending) begin
        pulseCnt  <= 2'h1;
        sweepDone <= 1'b0;
      end else if (pulseRise && state != ST_PREAMBLE) begin
        pulseCnt <= pulseCnt + 2'h1;
        if (pulseCnt == 2'(SWEEP_PULSES - 1)) begin
          sweepDone <= 1'b1;
        end
      end
    end
  end

  // Framer sequence: preamble, marker, sync, commutation cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_PREAMBLE;
    end else if (wordEnd) begin
      case (state)
        ST_PREAMBLE: begin
          if (markPending) begin
            state <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          state <= ST_SAMPLE;
        end
        ST_SAMPLE: begin
          if (chan == 5'(AUX_SLOT) && sweepDone) begin
            state <= ST_PREAMBLE;
          end
        end
        default: begin
          state <= ST_PREAMBLE;
        end
      endcase
    end
  end

  // Commutator; reset by the sync word so band 1 A always leads
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chan       <= 5'h00;
      firstCycle <= 1'b0;
    end else if (wordEnd) begin
      if (state == ST_SYNC) begin
        chan       <= 5'h00;
        firstCycle <= 1'b1;
      end else if (state == ST_SAMPLE) begin
        if (chan == 5'(AUX_SLOT)) begin
          chan       <= 5'h00;
          firstCycle <= 1'b0;
        end else begin
          chan <= chan + 5'h01;
        end
      end
    end
  end

  assign sweepActive = (state == ST_SAMPLE);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [9:0] cycTimer;  // Core clocks since last commutator restart
  logic       cycSeen;   // A restart has been seen before
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cycTimer <= 10'h000;
      cycSeen  <= 1'b0;
    end else if (wordEnd && state == ST_SAMPLE && chan == 5'(AUX_SLOT)) begin
      cycTimer <= 10'h001;
      cycSeen  <= 1'b1;
    end else if (state != ST_SAMPLE) begin
      cycSeen  <= 1'b0;
    end else begin
      cycTimer <= cycTimer + 10'h001;
    end
  end

  a_cycle_period: assert property (
    (wordEnd && state == ST_SAMPLE && chan == 5'(AUX_SLOT) && cycSeen) |-> cycTimer == 10'(CYCLE_CLKS))
    else $error("commutation cycle not 400 clocks");
  a_retrace_no_sample: assert property (
    $rose(sweepDone) |-> ##[1:440] (state == ST_PREAMBLE))
    else $error("sampling did not stop after east crossing");
  a_marker_invert: assert property (
    (wordEnd && state == ST_PREAMBLE && markPending) |=> (shiftReg == ~$past(preWord) && state == ST_SYNC))
    else $error("marker word not inverted preamble");
  a_preamble_idle: assert property (
    (wordEnd && state == ST_PREAMBLE && !markPending) |=> shiftReg == $past(preWord))
    else $error("idle word not preamble");
  a_sync_reset: assert property (
    (wordEnd && state == ST_SYNC) |=> (shiftReg == SYNC_CODE && chan == 5'h00 && firstCycle))
    else $error("sync word or commutator reset missing");
  a_time_insert: assert property (
    (sampleLoad && firstCycle) |=> shiftReg == $past(timeWord))
    else $error("time code not inserted in first cycle");
  a_band4_linear: assert property (
    (sampleLoad && !firstCycle && chan >= 5'(BAND4_FIRST)) |=> shiftReg == $past(linSample))
    else $error("band 4 sample not linear");
  a_bit_spacing: assert property (
    bitEn |=> !bitEn ##[1:2] bitEn)
    else $error("bit enable spacing wrong");

  c_marker:   cover property (wordEnd && state == ST_PREAMBLE && markPending);
  c_sweepend: cover property (wordEnd && state == ST_SAMPLE && chan == 5'(AUX_SLOT) && sweepDone);
  c_compress: cover property (sampleLoad && useCompress && !firstCycle);

endmodule // scan_video_mux_framer
`default_nettype wire

// ---- design/scan_mux_pkg.sv ----
package scan_mux_pkg;

  // Clock and link rates
  localparam int CORE_CLK_KHZ   = 40000;   // core_clk frequency
  localparam int CORE_PERIOD_NS = 25;      // core_clk period
  localparam int BIT_RATE_KHZ   = 15000;   // serial output rate, 15 Mbps
  localparam int COMMUTE_NS     = 10000;   // one commutation cycle, 10 us

  // Frame geometry
  localparam int WORD_BITS      = 6;       // every word on the line is 6 bits
  localparam int NUM_CHAN       = 24;      // 4 bands x 6 channels
  localparam int CHAN_PER_BAND  = 6;
  localparam int BAND4_FIRST    = 18;      // band 4 channels are 18..23
  localparam int SWEEP_PULSES   = 3;       // west, centre, east crossings

  // Derived counts
  localparam int CYCLE_CLKS     = COMMUTE_NS / CORE_PERIOD_NS;                        // 400
  localparam int WORDS_PER_CYC  = (COMMUTE_NS / 1000) * (BIT_RATE_KHZ / 1000) / WORD_BITS; // 25
  localparam int AUX_SLOT       = WORDS_PER_CYC - 1;                                  // 24

  // Fixed line words
  localparam logic [5:0] PREAMBLE_A = 6'h0F;
  localparam logic [5:0] PREAMBLE_B = 6'h33;
  localparam logic [5:0] SYNC_CODE  = 6'h27;
  localparam logic [5:0] FILL_WORD  = 6'h2D;

  // Compression path knee
  localparam logic [5:0] COMP_KNEE  = 6'h10;
  localparam logic [5:0] COMP_BASE  = 6'h20;

  // Framer states
  typedef enum logic [1:0] {
    ST_PREAMBLE = 2'b00,
    ST_SYNC     = 2'b01,
    ST_SAMPLE   = 2'b10
  } framer_state_t;

endpackage

// ---- design/sample_encoder.sv ----
`timescale 1ns/1ps
`default_nettype none
// Picks linear or companded code for one commutated sample
module sample_encoder
  import scan_mux_pkg::*;
(
  input  wire logic [5:0] linSample,
  input  wire logic       compress,
  output logic      [5:0] code
);

  logic [5:0] upper;  // Offset above the knee

  // Low levels are expanded x2, high levels squeezed /2 above the knee
  always_comb begin
    upper = linSample - COMP_KNEE;
    if (!compress) begin
      code = linSample;
    end else if (linSample < COMP_KNEE) begin
      code = {linSample[4:0], 1'b0};
    end else begin
      code = COMP_BASE + {1'b0, upper[5:1]};
    end
  end

endmodule // sample_encoder
`default_nettype wire

// ---- bench/scan_monitor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: mirror angle monitor plus a recorder that keeps every bit clocked out
module scan_monitor_model #(
  parameter int GAP = 2000  // Clocks between angle crossings
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic sweepGo,   // Bench asks for one forward sweep
  input  wire logic serData,
  input  wire logic serClk,
  output logic      scanPulse  // West, centre and east crossings
);
  int   sweepCnt;  // Clocks since the sweep began, 0 when idle
  logic bits[$];   // Recorded stream, oldest bit first

  // Three crossings per sweep, each four clocks wide, low otherwise
  always @(posedge core_clk) begin
    if (rst) begin
      sweepCnt  <= 0;
      scanPulse <= 1'b0;
    end else begin
      if (sweepGo) begin
        sweepCnt <= 1;
      end else if (sweepCnt != 0) begin
        sweepCnt <= (sweepCnt > 2 * GAP + 4) ? 0 : sweepCnt + 1;
      end
      scanPulse <= (sweepCnt >= 1 && sweepCnt <= 4) ||
                   (sweepCnt >= GAP && sweepCnt < GAP + 4) ||
                   (sweepCnt >= 2 * GAP && sweepCnt < 2 * GAP + 4);
    end
  end

  // Recorder takes the data line while the bit clock pulse is high
  always @(posedge core_clk) begin
    if (!rst && serClk) begin
      bits.push_back(serData);
    end
  end
endmodule  // scan_monitor_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin failCount++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import scan_mux_pkg::*;
  localparam int GAP = 2000;  // Crossing spacing, long enough for several cycles
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         compressMode = 1'b0;
  logic         sweepGo = 1'b0;
  logic         scanPulse, serData, serClk, sweepActive;
  logic [143:0] videoIn, timeCode;
  int           failCount = 0;
  int           checksDone = 0;

  always #12.5 core_clk = ~core_clk;

  scan_video_mux_framer scan_video_mux_framer_inst (.core_clk(core_clk), .rst(rst), .scanPulse(scanPulse),
    .compressMode(compressMode), .videoIn(videoIn), .timeCode(timeCode), .serData(serData),
    .serClk(serClk), .sweepActive(sweepActive));
  scan_monitor_model #(.GAP(GAP)) scan_monitor_model_inst (.core_clk(core_clk), .rst(rst),
    .sweepGo(sweepGo), .serData(serData), .serClk(serClk), .scanPulse(scanPulse));

  // Expected channel and time words, distinct per slot
  function automatic logic [5:0] vid(int k);
    return 6'((k * 5 + 3) % 64);
  endfunction
  function automatic logic [5:0] comp(logic [5:0] x);
    return (x < COMP_KNEE) ? 6'(x << 1) : 6'(COMP_BASE + ((x - COMP_KNEE) >> 1));
  endfunction
  // Six recorded bits from index i, first bit is the MSB
  function automatic logic [5:0] word_at(int i);
    logic [5:0] w;
    w = 6'h00;
    for (int b = 0; b < 6; b++) w = {w[4:0], scan_monitor_model_inst.bits[i + b]};
    return w;
  endfunction

  task automatic print_verdict;
    if (failCount == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Idle stream repeats every 12 bits with eight ones in each period
  task automatic check_preamble;
    int n;
    int ones;
    n = scan_monitor_model_inst.bits.size();
    ones = 0;
    for (int b = 0; b < 12; b++) begin
      ones += scan_monitor_model_inst.bits[n - 12 + b];
      `CHECK("preamble bit", scan_monitor_model_inst.bits[n - 24 + b], scan_monitor_model_inst.bits[n - 12 + b])
    end
    `CHECK("preamble ones", 8, ones)
  endtask

  // Outputs quiet in reset, then 150 bit clocks per 10 us
  task automatic check_reset_rate;
    int pulses;
    pulses = 0;
    `CHECK("serData in reset", PREAMBLE_A[5], serData)
    `CHECK("sweepActive in reset", 1'b0, sweepActive)
    @(negedge core_clk) rst = 1'b0;
    repeat (100) @(negedge core_clk);
    repeat (CYCLE_CLKS) begin
      @(negedge core_clk);
      if (serClk === 1'b1) pulses++;
    end
    `CHECK("bits per cycle", 150, pulses)
    check_preamble;
  endtask

  // One sweep: marker, sync, time cycle, then image cycles in slot order
  task automatic run_sweep(input logic cm);
    int i;
    int j;
    int n;
    logic [5:0] prev, exp;
    compressMode = cm;
    scan_monitor_model_inst.bits.delete();
    repeat (100) @(negedge core_clk);
    `CHECK("sweepActive before pulse", 1'b0, sweepActive)
    sweepGo = 1'b1;
    @(negedge core_clk) sweepGo = 1'b0;
    i = 0;
    while (sweepActive !== 1'b1) begin
      @(negedge core_clk);
      i++;
      if (i > 200) begin failCount++; print_verdict; end
    end
    `CHECK("sweepActive on pulse", 1'b1, sweepActive)
    `CHECK("marker and sync before sampling", 1'b1, i >= 16)
    repeat (2 * GAP + 1200) @(negedge core_clk);
    `CHECK("sweepActive after east", 1'b0, sweepActive)
    check_preamble;
    n = scan_monitor_model_inst.bits.size();
    j = -1;
    for (i = 12; i < n - 12 && j < 0; i++)
      if (word_at(i) === SYNC_CODE && word_at(i + 6) === timeCode[5:0]) j = i + 6;
    `CHECK("sync found", 1'b1, j > 0)
    if (j > 0) begin
      prev = word_at(j - 18);
      exp = ~((prev === PREAMBLE_A) ? PREAMBLE_B : PREAMBLE_A);
      `CHECK("marker word", exp, word_at(j - 12))
      for (int k = 0; k < NUM_CHAN; k++) `CHECK("time word", timeCode[6 * k +: 6], word_at(j + 6 * k))
      for (int c = 0; c < 3; c++) `CHECK("fill word", FILL_WORD, word_at(j + 150 * c + 144))
      for (int c = 1; c < 3; c++)
        for (int k = 0; k < NUM_CHAN; k++) begin
          exp = (cm && k < BAND4_FIRST) ? comp(vid(k)) : vid(k);
          `CHECK("sample word", exp, word_at(j + 150 * c + 6 * k))
        end
    end
  endtask

  initial begin
    for (int k = 0; k < NUM_CHAN; k++) begin
      videoIn[6 * k +: 6] = vid(k);
      timeCode[6 * k +: 6] = 6'h3F - 6'(k);
    end
    repeat (7) @(negedge core_clk);
    check_reset_rate;
    run_sweep(1'b0);
    run_sweep(1'b1);
    print_verdict;
  end
endmodule  // testbench
`default_nettype wire
